// [hw/mma_top.sv]
// Memory map arbiter: two masters, two internal targets, APB registers.
// Assumes targets answer read data in the cycle their select is high.
`timescale 1ns/1ns
`default_nettype none
module mma_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic mode_select_pin,
  input wire logic stop_mode,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Masters: 0 core, 1 debug unit
  input wire logic [1:0] m_valid,
  input wire mma_pkg::mma_req_s m_req [2],
  output logic [1:0] m_gnt,
  output logic [1:0] m_rvalid,
  output logic [7:0] m_rdata [2],
  // Targets: 0 internal memory, 1 peripherals
  output logic [1:0] t_sel,
  output mma_pkg::mma_acc_s t_acc [2],
  input wire logic [7:0] t_rdata [2],
  output logic sys_reset_req,
  output logic [7:0] map_visibility,
  output logic mode_normal
);
  import mma_pkg::*;

  logic rst_s1_q, rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Registers
  logic mode_q, mode_d, mode_lock_q, mode_lock_d, latched_q;
  logic zp_done_q, zp_done_d;
  logic [7:0] core_global_page_q, core_global_page_d, zpage_q, zpage_d, mapctl_q, mapctl_d;
  logic [7:0] prog_page_index_q, prog_page_index_d, dgpage_q, dgpage_d;
  logic [7:0] ram_page_index_q, ram_page_index_d, eeprom_page_index_q, eeprom_page_index_d;
  logic [31:0] prdata_q, prdata_d;

  wire [5:0] idx = paddr[7:2];
  wire wr = psel && penable && pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire special = mode_q != MODE_NORMAL;

  function automatic logic hit(input logic [5:0] i, input logic [7:0] r);
    hit = {2'b00, i} == r;
  endfunction

  wire mapped = hit(idx, IDX_RSVD_A) || hit(idx, IDX_MODE)
    || (idx >= IDX_CORE_GLOBAL_PAGE[5:0] && idx <= IDX_EEPROM_PAGE_INDEX[5:0]);

  // Mode bit: special may change freely; a normal-mode attempt to
  // leave normal is refused and locks the bit until reset
  wire mode_wr = wr && hit(idx, IDX_MODE) && !mode_lock_q;
  wire mode_bad = mode_wr && !special && wb[MODE_BIT] != MODE_NORMAL;
  assign mode_d = (mode_wr && !mode_bad) ? wb[MODE_BIT] : mode_q;
  assign mode_lock_d = mode_lock_q || mode_bad;

  wire zp_wr = wr && hit(idx, IDX_ZPAGE) && (special || !zp_done_q);
  assign zpage_d = zp_wr ? wb : zpage_q;
  assign zp_done_d = zp_done_q || (zp_wr && !special);

  assign core_global_page_d = (wr && hit(idx, IDX_CORE_GLOBAL_PAGE)) ? (wb & CORE_GLOBAL_PAGE_MASK)
    : core_global_page_q;
  assign mapctl_d = (wr && hit(idx, IDX_MAPCTL)) ? (wb & MAPCTL_MASK)
    : mapctl_q;
  assign prog_page_index_d = (wr && hit(idx, IDX_PROG_PAGE_INDEX)) ? wb : prog_page_index_q;
  assign dgpage_d = (wr && hit(idx, IDX_DGPAGE)) ? (wb & CORE_GLOBAL_PAGE_MASK)
    : dgpage_q;
  assign ram_page_index_d = (wr && hit(idx, IDX_RAM_PAGE_INDEX)) ? wb : ram_page_index_q;
  assign eeprom_page_index_d = (wr && hit(idx, IDX_EEPROM_PAGE_INDEX)) ? wb : eeprom_page_index_q;

  // Read mux; reserved words answer zero
  wire [7:0] rd_byte = hit(idx, IDX_MODE) ? {mode_q, 7'h00}
    : hit(idx, IDX_CORE_GLOBAL_PAGE) ? core_global_page_q
    : hit(idx, IDX_ZPAGE) ? zpage_q
    : hit(idx, IDX_MAPCTL) ? mapctl_q
    : hit(idx, IDX_PROG_PAGE_INDEX) ? prog_page_index_q
    : hit(idx, IDX_DGPAGE) ? dgpage_q
    : hit(idx, IDX_RAM_PAGE_INDEX) ? ram_page_index_q
    : hit(idx, IDX_EEPROM_PAGE_INDEX) ? eeprom_page_index_q
    : 8'h00;
  // Data captured in setup so the access phase needs no wait
  assign prdata_d = (psel && !penable) ? {24'h000000, rd_byte}
    : prdata_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_lock_q <= 1'b0;
      zp_done_q <= 1'b0;
      core_global_page_q <= RST_CORE_GLOBAL_PAGE;
      zpage_q <= RST_ZPAGE;
      mapctl_q <= RST_MAPCTL;
      prog_page_index_q <= RST_PROG_PAGE_INDEX;
      dgpage_q <= RST_CORE_GLOBAL_PAGE;
      ram_page_index_q <= RST_RAM_PAGE_INDEX;
      eeprom_page_index_q <= RST_EEPROM_PAGE_INDEX;
      prdata_q <= 32'h00000000;
    end else begin
      mode_lock_q <= mode_lock_d;
      zp_done_q <= zp_done_d;
      core_global_page_q <= core_global_page_d;
      zpage_q <= zpage_d;
      mapctl_q <= mapctl_d;
      prog_page_index_q <= prog_page_index_d;
      dgpage_q <= dgpage_d;
      ram_page_index_q <= ram_page_index_d;
      eeprom_page_index_q <= eeprom_page_index_d;
      prdata_q <= prdata_d;
    end
  end

  // Pin caught on the first edge after release, then software owns it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 1'b0;
      mode_q <= MODE_NORMAL;
    end else begin
      latched_q <= 1'b1;
      mode_q <= latched_q ? mode_d : mode_select_pin;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;
  assign map_visibility = mapctl_q;
  assign mode_normal = mode_q;

  // Translation per master
  logic [22:0] gaddr [2];
  mma_tgt_e tgt [2];
  wire [7:0] mgp [2] = '{core_global_page_q, dgpage_q};

  genvar m;
  generate
    for (m = 0; m < 2; m++) begin : g_xl
      mma_xlate u_xl (
        .req(m_req[m]),
        .core_global_page(mgp[m]),
        .zpage(zpage_q),
        .ram_page_index(ram_page_index_q),
        .eeprom_page_index(eeprom_page_index_q),
        .prog_page_index(prog_page_index_q),
        .prog_row_on(mapctl_q[PROG_ROW_BIT]),
        .gaddr(gaddr[m]),
        .tgt(tgt[m])
      );
    end
  endgenerate

  // Arbitration: different targets pass together, a shared target
  // alternates so neither master starves
  logic rr_q, rr_d;
  wire run = rst_n && latched_q && !stop_mode;
  wire clash = m_valid[0] && m_valid[1] && tgt[0] == tgt[1]
    && tgt[0] != TGT_NONE;
  assign m_gnt[0] = run && m_valid[0] && (!clash || !rr_q);
  assign m_gnt[1] = run && m_valid[1] && (!clash || rr_q);
  assign rr_d = clash ? !rr_q : rr_q;

  function automatic logic [1:0] tidx(input mma_tgt_e t);
    tidx = (t == TGT_MEM) ? 2'd0 : (t == TGT_PERIPH) ? 2'd1 : 2'd2;
  endfunction

  logic [1:0] tsel_d;
  logic [1:0] town_d;
  mma_acc_s tacc_d [2];
  logic [1:0] tsel_q, town_q;
  mma_acc_s tacc_q [2];

  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_tg
      wire g0 = m_gnt[0] && tidx(tgt[0]) == 2'(t);
      wire g1 = m_gnt[1] && tidx(tgt[1]) == 2'(t);
      assign tsel_d[t] = g0 || g1;
      assign town_d[t] = g1;
      assign tacc_d[t] = g1 ? {m_req[1].we, gaddr[1], m_req[1].wdata}
        : {m_req[0].we, gaddr[0], m_req[0].wdata};
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rr_q <= 1'b0;
      tsel_q <= 2'b00;
      town_q <= 2'b00;
      tacc_q <= '{default: '0};
    end else begin
      rr_q <= rr_d;
      tsel_q <= tsel_d;
      town_q <= town_d;
      tacc_q <= tacc_d;
    end
  end

  assign t_sel = tsel_q;
  assign t_acc = tacc_q;

  // Answers back to masters, one cycle after the target cycle
  logic [1:0] pend_q, rv_q;
  logic [1:0] ptgt_q [2];
  logic [7:0] rdat_q [2];
  logic [7:0] rdat_d [2];
  generate
    for (m = 0; m < 2; m++) begin : g_rd
      assign rdat_d[m] = !pend_q[m] ? rdat_q[m]
        : ptgt_q[m] == 2'd0 ? t_rdata[0]
        : ptgt_q[m] == 2'd1 ? t_rdata[1] : 8'h00;
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 2'b00;
      rv_q <= 2'b00;
      ptgt_q <= '{default: '0};
      rdat_q <= '{default: '0};
    end else begin
      pend_q <= m_gnt;
      rv_q <= pend_q;
      ptgt_q <= '{tidx(tgt[0]), tidx(tgt[1])};
      rdat_q <= rdat_d;
    end
  end

  assign m_rvalid = rv_q;
  assign m_rdata = rdat_q;

  // Core touching nothing implemented in single-chip mode resets chip
  logic rst_req_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= m_gnt[0] && tgt[0] == TGT_NONE;
    end
  end
  assign sys_reset_req = rst_req_q;
endmodule : mma_top
`default_nettype wire

// [include/mma_pkg.sv]
// Constants, types and register map of the memory map arbiter.
// Assumes a 100 MHz bus clock and APB register access, one byte per word.
package mma_pkg;
  localparam int unsigned LADDR_W = 16;
  localparam int unsigned GADDR_W = 23;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RSVD_A = 8'h0A;
  localparam logic [7:0] IDX_MODE = 8'h0B;
  localparam logic [7:0] IDX_CORE_GLOBAL_PAGE = 8'h10;
  localparam logic [7:0] IDX_ZPAGE = 8'h11;
  localparam logic [7:0] IDX_RSVD_B = 8'h12;
  localparam logic [7:0] IDX_MAPCTL = 8'h13;
  localparam logic [7:0] IDX_RSVD_C = 8'h14;
  localparam logic [7:0] IDX_PROG_PAGE_INDEX = 8'h15;
  localparam logic [7:0] IDX_DGPAGE = 8'h16;
  localparam logic [7:0] IDX_RAM_PAGE_INDEX = 8'h17;
  localparam logic [7:0] IDX_EEPROM_PAGE_INDEX = 8'h18;
  // Field positions and masks
  localparam int unsigned MODE_BIT = 7;
  localparam logic [7:0] CORE_GLOBAL_PAGE_MASK = 8'h7F;
  localparam logic [7:0] MAPCTL_MASK = 8'hB0;
  localparam int unsigned PROG_ROW_BIT = 4;
  // Reset values
  localparam logic [7:0] RST_CORE_GLOBAL_PAGE = 8'h00;
  localparam logic [7:0] RST_ZPAGE = 8'h00;
  localparam logic [7:0] RST_MAPCTL = 8'h00;
  localparam logic [7:0] RST_PROG_PAGE_INDEX = 8'hFE;
  localparam logic [7:0] RST_RAM_PAGE_INDEX = 8'hFD;
  localparam logic [7:0] RST_EEPROM_PAGE_INDEX = 8'hFE;
  // Mode bit: 1 normal single chip, 0 special single chip
  localparam logic MODE_NORMAL = 1'b1;
  // Local windows
  localparam logic [15:0] PERIPH_TOP = 16'h07FF;
  localparam logic [15:0] EWIN_BASE = 16'h0800;
  localparam logic [15:0] EWIN_TOP = 16'h0BFF;
  localparam logic [15:0] RWIN_BASE = 16'h1000;
  localparam logic [15:0] RWIN_TOP = 16'h1FFF;
  localparam logic [15:0] PWIN_BASE = 16'h8000;
  localparam logic [15:0] PWIN_TOP = 16'hBFFF;
  // Global regions
  localparam logic [22:0] G_PERIPH_TOP = 23'h0007FF;
  localparam logic [22:0] G_RAM_BASE = 23'h0F8000;
  localparam logic [22:0] G_RAM_TOP = 23'h0FFFFF;
  localparam logic [22:0] G_EE_BASE = 23'h100000;
  localparam logic [22:0] G_EE_TOP = 23'h13FFFF;
  localparam logic [22:0] G_ROW_BASE = 23'h400000;
  localparam logic [22:0] G_ROW_TOP = 23'h403FFF;
  localparam logic [22:0] G_FLASH_BASE = 23'h7C0000;
  localparam logic [22:0] G_FIXED_PAGE = 23'h7F0000;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b001,
    TGT_MEM = 3'b010,
    TGT_PERIPH = 3'b100
  } mma_tgt_e;

  typedef struct packed {
    logic we;
    logic glob;
    logic direct;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mma_req_s;

  typedef struct packed {
    logic we;
    logic [22:0] addr;
    logic [7:0] wdata;
  } mma_acc_s;
endpackage : mma_pkg

// [hw/mma_xlate.sv]
// Address translation and target decode for one bus master.
// Assumes page registers are stable while a request is presented.
`timescale 1ns/1ns
`default_nettype none
module mma_xlate (
  input wire mma_pkg::mma_req_s req,
  input wire logic [7:0] core_global_page,
  input wire logic [7:0] zpage,
  input wire logic [7:0] ram_page_index,
  input wire logic [7:0] eeprom_page_index,
  input wire logic [7:0] prog_page_index,
  input wire logic prog_row_on,
  output logic [22:0] gaddr,
  output mma_pkg::mma_tgt_e tgt
);
  import mma_pkg::*;

  wire [15:0] laddr = req.direct ? {zpage, req.addr[7:0]} : req.addr;
  wire in_per = laddr <= PERIPH_TOP;
  wire in_ee = laddr >= EWIN_BASE && laddr <= EWIN_TOP;
  wire in_ram = laddr >= RWIN_BASE && laddr <= RWIN_TOP;
  wire in_prg = laddr >= PWIN_BASE && laddr <= PWIN_TOP;
  wire [22:0] g_glob = {core_global_page[6:0], laddr};
  wire [22:0] g_loc = in_per ? {7'h00, laddr}
    : in_ee ? {3'b001, 2'b00, eeprom_page_index, laddr[9:0]}
    : in_ram ? {3'b000, ram_page_index, laddr[11:0]}
    : in_prg ? {1'b1, prog_page_index, laddr[13:0]}
    : G_FIXED_PAGE | {7'h00, laddr};

  assign gaddr = req.glob ? g_glob : g_loc;
  wire is_per = gaddr <= G_PERIPH_TOP;
  wire is_row = gaddr >= G_ROW_BASE && gaddr <= G_ROW_TOP;
  // Only internal regions exist; everything else is unimplemented
  wire is_mem = (gaddr >= G_RAM_BASE && gaddr <= G_RAM_TOP)
    || (gaddr >= G_EE_BASE && gaddr <= G_EE_TOP)
    || (is_row && prog_row_on)
    || gaddr >= G_FLASH_BASE;
  assign tgt = is_per ? TGT_PERIPH : is_mem ? TGT_MEM : TGT_NONE;
endmodule : mma_xlate
`default_nettype wire

// [testbench/mma_asserts.sv]
// Port-level checks for the memory map arbiter.
// Assumes binding to mma_top; core page tracked from APB writes.
`timescale 1ns/1ns
`default_nettype none
module mma_asserts (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic mode_select_pin,
  input wire logic stop_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] m_valid,
  input wire mma_pkg::mma_req_s m_req [2],
  input wire logic [1:0] m_gnt,
  input wire logic [1:0] m_rvalid,
  input wire logic [1:0] t_sel,
  input wire mma_pkg::mma_acc_s t_acc [2],
  input wire logic sys_reset_req,
  input wire logic mode_normal
);
  import mma_pkg::*;
  logic [6:0] gp_q;
  logic tk_q;
  logic [22:0] ga_q;
  wire gp_wr = psel && penable && pwrite && paddr == 8'h40;
  wire tk_d = m_valid[0] && m_gnt[0] && m_req[0].glob && !m_req[0].direct;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gp_q <= 7'h00;
      tk_q <= 1'b0;
      ga_q <= 23'h000000;
    end else begin
      if (gp_wr) gp_q <= pwdata[6:0];
      tk_q <= tk_d;
      ga_q <= {gp_q, m_req[0].addr};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_quiet;
    m_gnt == 2'b00 ##1 t_sel == 2'b00;
  endsequence
  property p_stop;
    stop_mode |-> s_quiet;
  endproperty
  a_stop: assert property (p_stop) else $error("grant in stop");
  property p_ans;
    m_rvalid == $past(m_valid & m_gnt, 2);
  endproperty
  a_ans: assert property (p_ans) else $error("answer timing");
  property p_tsel;
    $countones(t_sel) <= $countones($past(m_valid & m_gnt));
  endproperty
  a_tsel: assert property (p_tsel) else $error("stray select");
  property p_coll;
    m_valid == 2'b11 && m_req[0] == m_req[1] && !m_req[0].glob
      |-> $onehot0(m_gnt);
  endproperty
  a_coll: assert property (p_coll) else $error("double grant");
  property p_rst;
    sys_reset_req |-> $past(m_gnt[0]) || $past(m_gnt[0], 2);
  endproperty
  a_rst: assert property (p_rst) else $error("stray reset");
  property p_glob;
    tk_q |-> t_sel == 2'b00 || (t_sel[0] && t_acc[0].addr == ga_q)
      || (t_sel[1] && t_acc[1].addr == ga_q);
  endproperty
  a_glob: assert property (p_glob) else $error("global addr");
  property p_mode;
    $rose(nrst) |-> ##4 mode_normal == mode_select_pin;
  endproperty
  a_mode: assert property (p_mode) else $error("mode latch");
  property p_apb;
    psel && penable && paddr inside {8'h28, 8'h48, 8'hFC}
      |-> pready && pslverr == (paddr == 8'hFC);
  endproperty
  a_apb: assert property (p_apb) else $error("apb error flag");
endmodule : mma_asserts
bind mma_top mma_asserts u_mma_asserts (.sys_clk, .nrst, .mode_select_pin,
  .stop_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .m_valid, .m_req, .m_gnt, .m_rvalid, .t_sel, .t_acc, .sys_reset_req,
  .mode_normal);
`default_nettype wire

// [testbench/mma_tgt_model.sv]
// Behavioural memory and peripheral targets of the arbiter.
// Assumes one-cycle selects; read data is the address hashed by a key.
`timescale 1ns/1ns
`default_nettype none
module mma_tgt_model #(
  parameter logic [7:0] KEY0 = 8'h5A,
  parameter logic [7:0] KEY1 = 8'hA5
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [1:0] t_sel,
  input wire mma_pkg::mma_acc_s t_acc [2],
  output logic [7:0] t_rdata [2]
);
  import mma_pkg::*;
  logic [7:0] junk_q;
  // Idle data churns so a stale byte cannot pass
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) junk_q <= 8'h3C;
    else junk_q <= ~junk_q + 8'h01;
  end
  assign t_rdata[0] = t_sel[0] ? t_acc[0].addr[7:0] ^ KEY0 : junk_q;
  assign t_rdata[1] = t_sel[1] ? t_acc[1].addr[7:0] ^ KEY1 : junk_q;
endmodule : mma_tgt_model
`default_nettype wire

// [testbench/mma_top_test.sv]
// Self-checking bench: APB registers, both masters, target model.
// Assumes the checker is attached by its own bind.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_count++; $display("unexpected %0t got %h want %h", $time, a, b); \
  end end
module mma_top_test;
  import mma_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic mode_select_pin = 1'b1;
  logic stop_mode = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] m_valid = 2'b00;
  mma_req_s m_req [2] = '{default: '0};
  logic [1:0] m_gnt;
  logic [1:0] m_rvalid;
  logic [1:0] t_sel;
  logic [7:0] m_rdata [2];
  mma_acc_s t_acc [2];
  logic [7:0] t_rdata [2];
  logic sys_reset_req;
  logic mode_normal;
  logic [7:0] map_visibility;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int samples_checked = 0;
  int rst_seen = 0;
  mma_top u_mma_top (.sys_clk, .nrst, .mode_select_pin, .stop_mode, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .m_valid,
    .m_req, .m_gnt, .m_rvalid, .m_rdata, .t_sel, .t_acc, .t_rdata,
    .sys_reset_req, .map_visibility, .mode_normal);
  mma_tgt_model #(.KEY0(8'h5A), .KEY1(8'hA5)) u_mma_tgt_model (.sys_clk,
    .nrst, .t_sel, .t_acc, .t_rdata);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sys_reset_req === 1'b1) rst_seen++;
  task automatic final_report;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  task automatic rst(input logic pin);
    @(posedge sys_clk);
    nrst <= 1'b0;
    mode_select_pin <= pin;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : rst
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i[5:0], 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled access
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask : rreg
  function automatic mma_req_s rq(input logic g, d, input logic [15:0] a);
    return '{1'b0, g, d, a, 8'h00};
  endfunction : rq
  task automatic acc(input int m, input mma_req_s q, input logic [1:0] ts,
    input logic [22:0] ga);
    int n;
    logic [7:0] ex;
    ex = ts == 2'b00 ? 8'h00 : ga[7:0] ^ (ts[1] ? 8'hA5 : 8'h5A);
    @(posedge sys_clk);
    m_valid[m] <= 1'b1;
    m_req[m] <= q;
    n = 0;
    do @(posedge sys_clk); while (m_gnt[m] !== 1'b1 && ++n < 20);
    m_valid[m] <= 1'b0;
    @(posedge sys_clk);
    `CHK(t_sel, ts)
    if (ts != 2'b00) `CHK(t_acc[ts[1]].addr, ga)
    @(posedge sys_clk);
    `CHK(m_rvalid[m], 1'b1)
    `CHK(m_rdata[m], ex)
  endtask : acc
  task automatic pair(input mma_req_s q0, q1, input logic [1:0] g);
    @(posedge sys_clk);
    m_valid <= 2'b11;
    m_req[0] <= q0;
    m_req[1] <= q1;
    @(posedge sys_clk);
    `CHK(m_gnt, g)
    m_valid <= ~g;
    @(posedge sys_clk);
    `CHK(t_sel, g == 2'b11 ? 2'b11 : 2'b01)
    `CHK(m_gnt & ~g, ~g)
    m_valid <= 2'b00;
  endtask : pair
  task automatic t_regs;
    rreg(IDX_MODE, 8'h80);
    rreg(IDX_PROG_PAGE_INDEX, 8'hFE);
    rreg(IDX_RAM_PAGE_INDEX, 8'hFD);
    rreg(IDX_EEPROM_PAGE_INDEX, 8'hFE);
    rreg(IDX_MAPCTL, 8'h00);
    apb(1'b1, IDX_RSVD_A, 8'hFF);
    rreg(IDX_RSVD_A, 8'h00);
    apb(1'b1, IDX_RSVD_B, 8'hFF);
    `CHK(er, 1'b0)
    apb(1'b1, 8'h3F, 8'hFF);
    `CHK(er, 1'b1)
    apb(1'b1, IDX_CORE_GLOBAL_PAGE, 8'hFF);
    rreg(IDX_CORE_GLOBAL_PAGE, 8'h7F);
    apb(1'b1, IDX_MAPCTL, 8'hFF);
    rreg(IDX_MAPCTL, 8'hB0);
    `CHK(map_visibility, 8'hB0)
    apb(1'b1, IDX_ZPAGE, 8'h12);
    apb(1'b1, IDX_ZPAGE, 8'h34);
    rreg(IDX_ZPAGE, 8'h12);
    apb(1'b1, IDX_MODE, 8'h00);
    rreg(IDX_MODE, 8'h80);
  endtask : t_regs
  task automatic t_xlate;
    acc(0, rq(0, 0, 16'h0123), 2'b10, 23'h000123);
    acc(0, rq(0, 0, 16'h0845), 2'b01, 23'h13F845);
    acc(1, rq(0, 0, 16'h1ABC), 2'b01, 23'h0FDABC);
    acc(0, rq(0, 0, 16'h9234), 2'b01, 23'h7F9234);
    acc(0, rq(0, 0, 16'hC567), 2'b01, 23'h7FC567);
    acc(0, rq(0, 1, 16'h00AB), 2'b01, 23'h0FD2AB);
    apb(1'b1, IDX_CORE_GLOBAL_PAGE, 8'h0F);
    apb(1'b1, IDX_DGPAGE, 8'h7C);
    acc(0, rq(1, 0, 16'h8123), 2'b01, 23'h0F8123);
    acc(1, rq(1, 0, 16'h0010), 2'b01, 23'h7C0010);
    apb(1'b1, IDX_PROG_PAGE_INDEX, 8'h00);
    acc(1, rq(0, 0, 16'h8010), 2'b01, 23'h400010);
    apb(1'b1, IDX_MAPCTL, 8'h00);
    acc(1, rq(0, 0, 16'h8010), 2'b00, 23'h000000);
    acc(0, rq(1, 0, 16'h0000), 2'b00, 23'h000000);
    @(posedge sys_clk);
    `CHK(rst_seen, 1)
  endtask : t_xlate
  task automatic t_stop;
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    m_valid[0] <= 1'b1;
    m_req[0] <= rq(0, 0, 16'h0123);
    repeat (3) begin
      @(posedge sys_clk);
      `CHK(m_gnt, 2'b00)
    end
    stop_mode <= 1'b0;
    @(posedge sys_clk);
    `CHK(m_gnt, 2'b01)
    m_valid <= 2'b00;
  endtask : t_stop
  task automatic t_spec;
    rst(1'b0);
    rreg(IDX_MODE, 8'h00);
    apb(1'b1, IDX_ZPAGE, 8'h21);
    apb(1'b1, IDX_ZPAGE, 8'h43);
    rreg(IDX_ZPAGE, 8'h43);
    apb(1'b1, IDX_MODE, 8'h80);
    rreg(IDX_MODE, 8'h80);
  endtask : t_spec
  initial begin
    rst(1'b1);
    t_regs();
    t_xlate();
    pair(rq(0, 0, 16'h1ABC), rq(0, 0, 16'h1ABC), 2'b01);
    pair(rq(0, 0, 16'h1ABC), rq(0, 0, 16'h1ABC), 2'b10);
    pair(rq(0, 0, 16'h1ABC), rq(0, 0, 16'h0123), 2'b11);
    t_stop();
    t_spec();
    final_report();
  end
  initial begin
    #100000;
    err_count++;
    final_report();
  end
endmodule : mma_top_test
`default_nettype wire
